//--- hdl/fpnnu_top.sv
// fixed-point negated magnitude, inverted and, and negate unit
// assumes issue inputs and register port are driven on CLK by core logic
`timescale 1ns/10ps
`default_nettype none
module fpnnu_top
  import fpnnu_pkg::*;
#(
  parameter int unsigned DW = 32
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic ISSUE_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [DW-1:0] OPND_A,
  input wire logic [DW-1:0] OPND_S,
  input wire logic [DW-1:0] OPND_B,
  output logic WB_VALID,
  output logic [4:0] WB_INDEX,
  output logic [DW-1:0] WB_DATA,
  output logic ILLEGAL,
  output logic SO_FLAG,
  output logic OV_FLAG,
  output logic CA_FLAG,
  output logic [3:0] CMP0_FIELD,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  fpnnu_op_t op;
  logic prim_hit;
  logic chk;
  logic rec;
  logic [4:0] tgt_idx;
  logic [4:0] fa_idx;
  assign prim_hit = INSTR[PRIM_HI:PRIM_LO] == PRIM_OP;
  assign chk = INSTR[CHK_BIT];
  assign rec = INSTR[REC_BIT];
  assign tgt_idx = INSTR[TGT_HI:TGT_LO];
  assign fa_idx = INSTR[FA_HI:FA_LO];
  // bits 16-20 are don't-care for the single-source forms
  always_comb
  begin
    op = OP_NONE;
    if (prim_hit)
    begin
      if (INSTR[CHK_BIT:XO_LO] == XO_NAND)
        op = OP_NAND;
      else if (INSTR[XO9_HI:XO_LO] == XO_NABS)
        op = OP_NABS;
      else if (INSTR[XO9_HI:XO_LO] == XO_NEG)
        op = OP_NEG;
    end
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic signed [DW-1:0] a_s;
  logic [DW-1:0] neg_res;
  logic [DW-1:0] res;
  logic [4:0] wb_idx;
  logic neg_ovf;
  assign a_s = $signed(OPND_A);
  assign neg_res = (~OPND_A) + {{(DW-1){1'b0}}, 1'b1};
  // the most negative value wraps to itself, no special case needed
  assign neg_ovf = OPND_A == MOST_NEG[DW-1:0];
  always_comb
  begin
    res = '0;
    wb_idx = tgt_idx;
    case (op)
      OP_NABS: res = (a_s < 0) ? OPND_A : neg_res;
      OP_NEG: res = neg_res;
      OP_NAND:
      begin
        res = ~(OPND_S & OPND_B);
        wb_idx = fa_idx;
      end
      default: res = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // exception flags; an instruction update beats a software write
  // ----------------------------------------------------------------
  logic so_q;
  logic ov_q;
  logic ca_q;
  logic so_d;
  logic ov_d;
  logic ca_d;
  logic fire;
  logic sw_flags;
  assign fire = ISSUE_VALID && op != OP_NONE;
  assign sw_flags = REG_WR && REG_ADDR == ADR_FLAGS;
  always_comb
  begin
    so_d = sw_flags ? REG_WDATA[FLG_SO] : so_q;
    ov_d = sw_flags ? REG_WDATA[FLG_OV] : ov_q;
    ca_d = sw_flags ? REG_WDATA[FLG_CA] : ca_q;
    if (fire && chk && op == OP_NABS)
    begin
      so_d = so_q;
      ov_d = 1'b0;
    end
    else if (fire && chk && op == OP_NEG)
    begin
      ov_d = neg_ovf;
      so_d = so_q | neg_ovf;
    end
  end
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      so_q <= FLAGS_RST[FLG_SO];
      ov_q <= FLAGS_RST[FLG_OV];
      ca_q <= FLAGS_RST[FLG_CA];
    end
    else
    begin
      so_q <= so_d;
      ov_q <= ov_d;
      ca_q <= ca_d;
    end
  end

  // ----------------------------------------------------------------
  // compare field zero: lt, gt, eq, sticky copy
  // ----------------------------------------------------------------
  logic [3:0] cmp0_q;
  logic res_neg;
  logic res_zero;
  assign res_neg = $signed(res) < 0;
  assign res_zero = res == '0;
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      cmp0_q <= CMP0_RST;
    else if (fire && rec)
      // sticky copy sees this instruction's own overflow
      cmp0_q <= {res_neg, !res_neg && !res_zero, res_zero, so_d};
  end

  // ----------------------------------------------------------------
  // writeback
  // ----------------------------------------------------------------
  logic wb_valid_q;
  logic [4:0] wb_index_q;
  logic [DW-1:0] wb_data_q;
  logic illegal_q;
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wb_valid_q <= 1'b0;
      wb_index_q <= 5'h00;
      wb_data_q <= '0;
      illegal_q <= 1'b0;
    end
    else
    begin
      wb_valid_q <= fire;
      illegal_q <= ISSUE_VALID && op == OP_NONE;
      if (fire)
      begin
        wb_index_q <= wb_idx;
        wb_data_q <= res;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, enable, clear; a set wins over a clear
  // ----------------------------------------------------------------
  logic [2:0] ev;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] ien_q;
  logic [2:0] ien_d;
  logic irq_q;
  always_comb
  begin
    ev = 3'h0;
    ev[EV_DONE] = fire;
    ev[EV_OVF] = fire && chk && op == OP_NEG && neg_ovf;
    ev[EV_ILL] = ISSUE_VALID && op == OP_NONE;
    stat_d = stat_q;
    if (REG_WR && REG_ADDR == ADR_ICLR)
      stat_d = stat_d & ~REG_WDATA[2:0];
    stat_d = stat_d | ev;
    ien_d = (REG_WR && REG_ADDR == ADR_IEN) ? REG_WDATA[2:0] : ien_q;
  end
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      stat_q <= 3'h0;
      ien_q <= IEN_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      ien_q <= ien_d;
      irq_q <= |(stat_d & ien_d);
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= 32'h0000_0000;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        ADR_FLAGS: rdata_q <= {29'h0, so_q, ov_q, ca_q};
        ADR_CMP0: rdata_q <= {28'h0, cmp0_q};
        ADR_ISTAT: rdata_q <= {29'h0, stat_q};
        ADR_IEN: rdata_q <= {29'h0, ien_q};
        ADR_RESULT: rdata_q <= wb_data_q[31:0];
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      rdata_q <= 32'h0000_0000;
  end

  assign WB_VALID = wb_valid_q;
  assign WB_INDEX = wb_index_q;
  assign WB_DATA = wb_data_q;
  assign ILLEGAL = illegal_q;
  assign SO_FLAG = so_q;
  assign OV_FLAG = ov_q;
  assign CA_FLAG = ca_q;
  assign CMP0_FIELD = cmp0_q;
  assign REG_RDATA = rdata_q;
  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_q);

  property p_nabs_result;
    ISSUE_VALID && op == OP_NABS |=> WB_VALID && WB_INDEX == $past(tgt_idx)
      && ($signed(WB_DATA) <= 0) && (WB_DATA == $past(OPND_A) || WB_DATA == $past(neg_res));
  endproperty
  a_nabs_result: assert property (p_nabs_result) else $error("magnitude result wrong");

  property p_nabs_flags;
    ISSUE_VALID && op == OP_NABS && chk && !sw_flags |=> !OV_FLAG && SO_FLAG == $past(so_q);
  endproperty
  a_nabs_flags: assert property (p_nabs_flags) else $error("magnitude flags wrong");

  property p_nand_result;
    ISSUE_VALID && op == OP_NAND |=> WB_DATA == ~($past(OPND_S) & $past(OPND_B))
      && WB_INDEX == $past(fa_idx);
  endproperty
  a_nand_result: assert property (p_nand_result) else $error("nand result wrong");

  property p_nand_flags;
    ISSUE_VALID && op == OP_NAND && !sw_flags |=> $stable({SO_FLAG, OV_FLAG, CA_FLAG});
  endproperty
  a_nand_flags: assert property (p_nand_flags) else $error("nand changed flags");

  property p_neg_result;
    ISSUE_VALID && op == OP_NEG |=> WB_DATA == (~$past(OPND_A)) + 32'h1 && WB_VALID;
  endproperty
  a_neg_result: assert property (p_neg_result) else $error("negate result wrong");

  property p_neg_ovf;
    ISSUE_VALID && op == OP_NEG && chk && OPND_A == MOST_NEG
      |=> OV_FLAG && SO_FLAG && WB_DATA == MOST_NEG ##1 IRQ || !ien_q[EV_OVF];
  endproperty
  a_neg_ovf: assert property (p_neg_ovf) else $error("negate overflow missed");

  property p_ca_kept;
    ISSUE_VALID && !sw_flags |=> CA_FLAG == $past(ca_q);
  endproperty
  a_ca_kept: assert property (p_ca_kept) else $error("carry disturbed");

  property p_no_rec;
    ISSUE_VALID && !rec |=> $stable(CMP0_FIELD);
  endproperty
  a_no_rec: assert property (p_no_rec) else $error("compare field changed");

  property p_no_chk;
    ISSUE_VALID && !chk && !sw_flags |=> $stable({SO_FLAG, OV_FLAG});
  endproperty
  a_no_chk: assert property (p_no_chk) else $error("flags changed without check");

  property p_cmp0;
    fire && rec |=> CMP0_FIELD[3] == WB_DATA[31] && CMP0_FIELD[1] == (WB_DATA == '0)
      && CMP0_FIELD[0] == SO_FLAG && $onehot(CMP0_FIELD[3:1]);
  endproperty
  a_cmp0: assert property (p_cmp0) else $error("compare field wrong");

  c_nabs_rec: cover property (ISSUE_VALID && op == OP_NABS && rec);
  c_nand: cover property (ISSUE_VALID && op == OP_NAND);
  c_neg_ovf: cover property (ev[EV_OVF] ##1 IRQ);
  c_illegal: cover property (ILLEGAL);
endmodule
`default_nettype wire

//--- hdl/fpnnu_pkg.sv
// constants for the fixed-point negate / nand execution unit
// assumes instruction words and operands come from core issue logic on CLK
`default_nettype none
package fpnnu_pkg;
  // ----------------------------------------------------------------
  // instruction fields (bit k of the word in big-endian numbering is
  // bit 31-k of the vector)
  // ----------------------------------------------------------------
  localparam int unsigned PRIM_HI = 31;
  localparam int unsigned PRIM_LO = 26;
  localparam int unsigned TGT_HI = 25;
  localparam int unsigned TGT_LO = 21;
  localparam int unsigned FA_HI = 20;
  localparam int unsigned FA_LO = 16;
  localparam int unsigned FB_HI = 15;
  localparam int unsigned FB_LO = 11;
  localparam int unsigned CHK_BIT = 10;
  localparam int unsigned XO9_HI = 9;
  localparam int unsigned XO_LO = 1;
  localparam int unsigned REC_BIT = 0;
  localparam logic [5:0] PRIM_OP = 6'h1f;
  localparam logic [8:0] XO_NABS = 9'h1e8;
  localparam logic [8:0] XO_NEG = 9'h068;
  localparam logic [9:0] XO_NAND = 10'h1dc;
  localparam logic [31:0] MOST_NEG = 32'h8000_0000;
  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_FLAGS = 4'h0;
  localparam logic [3:0] ADR_CMP0 = 4'h1;
  localparam logic [3:0] ADR_ISTAT = 4'h2;
  localparam logic [3:0] ADR_IEN = 4'h3;
  localparam logic [3:0] ADR_ICLR = 4'h4;
  localparam logic [3:0] ADR_RESULT = 4'h5;
  localparam int unsigned FLG_CA = 0;
  localparam int unsigned FLG_OV = 1;
  localparam int unsigned FLG_SO = 2;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_OVF = 1;
  localparam int unsigned EV_ILL = 2;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [3:0] CMP0_RST = 4'h0;
  localparam logic [2:0] IEN_RST = 3'h0;
  typedef enum logic [1:0] {OP_NONE, OP_NABS, OP_NAND, OP_NEG} fpnnu_op_t;
endpackage
`default_nettype wire

//--- tb/fpnnu_core_model.sv
// issue-side model: register file that feeds operands and takes write-backs
// assumes the unit answers one cycle after issue, on the same clock
`timescale 1ns/10ps
`default_nettype none
module fpnnu_core_model (
  input wire logic clk,
  output logic issue_valid,
  output logic [31:0] instr,
  output logic [31:0] opnd_a,
  output logic [31:0] opnd_s,
  output logic [31:0] opnd_b,
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [31:0] wb_data
);
  logic [31:0] gpr [32];

  initial
  begin
    issue_valid = 1'b0;
    instr = 32'h0;
    opnd_a = 32'h0;
    opnd_s = 32'h0;
    opnd_b = 32'h0;
  end

  always @(posedge clk)
  begin
    if (wb_valid === 1'b1)
    begin
      gpr[wb_index] <= wb_data;
    end
  end

  // operands are inverted between issues so a stale value never passes for a fresh one
  task automatic issue(input logic [31:0] w);
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= w;
    opnd_a <= gpr[w[20:16]];
    opnd_s <= gpr[w[25:21]];
    opnd_b <= gpr[w[15:11]];
    @(posedge clk);
    issue_valid <= 1'b0;
    instr <= ~w;
    opnd_a <= ~opnd_a;
    opnd_s <= ~opnd_s;
    opnd_b <= ~opnd_b;
  endtask
endmodule
`default_nettype wire

//--- tb/fpnnu_bench.sv
// self-checking bench for the negate / nand unit
// assumes the issue model and the register port answer one cycle after a request
`timescale 1ns/10ps
`default_nettype none
module fpnnu_bench;
  import fpnnu_pkg::*;
  logic clk, nrst, iv, wbv, ill, so, ov, ca, rwr, rrd, irq;
  logic [31:0] ins, oa, os, ob, wbd, rwd, rdat;
  logic [4:0] wbi;
  logic [3:0] cmp, radr;
  int mismatches, n_compared;

  fpnnu_top uut (.CLK(clk), .NRST(nrst), .ISSUE_VALID(iv), .INSTR(ins), .OPND_A(oa),
    .OPND_S(os), .OPND_B(ob), .WB_VALID(wbv), .WB_INDEX(wbi), .WB_DATA(wbd), .ILLEGAL(ill),
    .SO_FLAG(so), .OV_FLAG(ov), .CA_FLAG(ca), .CMP0_FIELD(cmp), .REG_ADDR(radr),
    .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat), .IRQ(irq));
  fpnnu_core_model m (.clk(clk), .issue_valid(iv), .instr(ins), .opnd_a(oa), .opnd_s(os),
    .opnd_b(ob), .wb_valid(wbv), .wb_index(wbi), .wb_data(wbd));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] mk(input logic [9:0] xo, input logic [4:0] f1,
    input logic [4:0] f2, input logic [4:0] f3, input logic rec);
    return {PRIM_OP, f1, f2, f3, xo, rec};
  endfunction

  task automatic go(input logic [31:0] w, input logic [31:0] a, input logic [31:0] s,
    input logic [31:0] b, input logic [31:0] ed, input logic [2:0] ef, input logic [3:0] ec);
    m.gpr[w[20:16]] = a;
    m.gpr[w[25:21]] = s;
    m.gpr[w[15:11]] = b;
    m.issue(w);
    #1;
    chk("wb_valid", 32'h1, {31'h0, wbv});
    chk("wb_index", 32'h6, {27'h0, wbi});
    chk("wb_data", ed, wbd);
    chk("flags", {29'h0, ef}, {29'h0, so, ov, ca});
    chk("cmp0", {28'h0, ec}, {28'h0, cmp});
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rwr <= 1'b1;
    radr <= a;
    rwd <= d;
    @(posedge clk);
    rwr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rrd <= 1'b1;
    radr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    chk("reg_rdata", e, rdat);
    // read data must drop back to zero once its cycle is over
    @(posedge clk);
    #1;
    chk("reg_rdata_idle", 32'h0, rdat);
  endtask

  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    mismatches = 0;
    n_compared = 0;
    nrst = 1'b0;
    rwr = 1'b0;
    rrd = 1'b0;
    radr = 4'h0;
    rwd = 32'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // carry is preset so any write to it by an instruction shows
    reg_wr(ADR_FLAGS, 32'h1);
    go(mk({1'b0, XO_NABS}, 6, 4, 9, 0), 32'h3000, 0, 1, 32'hffff_d000, 3'h1, 4'h0);
    go(mk({1'b0, XO_NABS}, 6, 4, 0, 1), 32'hffff_ffff, 0, 0, 32'hffff_ffff, 3'h1, 4'h8);
    // overflowing operand without the check bit must leave every flag alone
    go(mk({1'b0, XO_NEG}, 6, 4, 0, 0), MOST_NEG, 0, 0, MOST_NEG, 3'h1, 4'h8);
    go(mk({1'b1, XO_NEG}, 6, 4, 0, 1), MOST_NEG, 0, 0, MOST_NEG, 3'h7, 4'h9);
    go(mk({1'b1, XO_NABS}, 6, 4, 0, 1), MOST_NEG, 0, 0, MOST_NEG, 3'h5, 4'h9);
    go(mk(XO_NAND, 4, 6, 7, 1), 0, 32'h9000_3000, 32'h789a_789b, 32'hefff_cfff, 3'h5, 4'h9);
    go(mk(XO_NAND, 4, 6, 7, 1), 0, 32'hffff_ffff, MOST_NEG, 32'h7fff_ffff, 3'h5, 4'h5);
    // zero result without the record bit must not reach the compare field
    go(mk(XO_NAND, 4, 6, 7, 0), 0, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 3'h5, 4'h5);
    go(mk({1'b0, XO_NEG}, 6, 4, 0, 0), 32'h9000_3000, 0, 0, 32'h6fff_d000, 3'h5, 4'h5);
    go(mk({1'b1, XO_NEG}, 6, 4, 0, 1), 32'h0, 0, 0, 32'h0, 3'h5, 4'h3);
    go(mk({1'b0, XO_NABS}, 6, 4, 0, 1), 32'h5, 0, 0, 32'hffff_fffb, 3'h5, 4'h9);
    m.issue(mk(10'h0eb, 6, 4, 5, 1));
    #1;
    chk("illegal", 32'h1, {31'h0, ill});
    chk("wb_valid", 32'h0, {31'h0, wbv});
    reg_rd(ADR_FLAGS, 32'h5);
    reg_rd(ADR_RESULT, 32'hffff_fffb);
    chk("irq", 32'h0, {31'h0, irq});
    reg_wr(ADR_IEN, 32'h2);
    reg_rd(ADR_ISTAT, 32'h7);
    chk("irq", 32'h1, {31'h0, irq});
    reg_wr(ADR_ICLR, 32'h2);
    reg_wr(ADR_CMP0, 32'hf);
    reg_rd(ADR_ISTAT, 32'h5);
    chk("irq", 32'h0, {31'h0, irq});
    reg_rd(ADR_CMP0, 32'h9);
    reg_rd(4'hf, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
